//--- logic/mix_router_cfg.svh
// Offsets, field positions, reset values and widths of the mix router.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MIX_ROUTER_CFG_SVH
`define MIX_ROUTER_CFG_SVH

`define SAMPLE_W 24
`define WB_ADR_W 8
`define REG_W 16
`define GAIN_FRAC_BITS 15

// Register indices; byte address is four times the index
`define ROUTING_IDX 6'h18
`define SIDETONE_IDX 6'h20
`define POLARITY_IDX 6'h26
`define MIX_CTRL_IDX 6'h30
`define MIX_STATUS_IDX 6'h31

`define ROUTING_RESET 16'h0050
`define SIDETONE_RESET 16'h0000
`define POLARITY_RESET 16'h0000
`define MIX_CTRL_RESET 16'h0000
`define MIX_STATUS_RESET 16'h0000

`define ROUTING_WMASK 16'h1ef0
`define SIDETONE_WMASK 16'h0fff
`define POLARITY_WMASK 16'h0003
`define MIX_CTRL_WMASK 16'h0001

// Field positions
`define PLAYBACK_FLIP_L_BIT 12
`define PLAYBACK_FLIP_R_BIT 11
`define BOOST_HI 10
`define BOOST_LO 9
`define TX_SLOT_L_BIT 7
`define TX_SLOT_R_BIT 6
`define PLAYBACK_SEL_L_BIT 5
`define PLAYBACK_SEL_R_BIT 4
`define MON_GAIN_L_HI 11
`define MON_GAIN_L_LO 8
`define MON_GAIN_R_HI 7
`define MON_GAIN_R_LO 4
`define MON_SRC_L_HI 3
`define MON_SRC_L_LO 2
`define MON_SRC_R_HI 1
`define MON_SRC_R_LO 0
`define ADC_FLIP_L_BIT 1
`define ADC_FLIP_R_BIT 0
`define RATE_MATCH_BIT 0
`define ST_BOOST_CLIP_L_BIT 0
`define ST_BOOST_CLIP_R_BIT 1
`define ST_MIX_CLIP_L_BIT 2
`define ST_MIX_CLIP_R_BIT 3

`endif

//--- logic/mix_router_pkg.sv
// Types shared by the mix router modules.
// Assumes mix_router_cfg.svh is on the include path.
`include "mix_router_cfg.svh"

package mix_router_pkg;
    typedef logic signed [`SAMPLE_W-1:0] sample_t;
    typedef enum logic [1:0] {
        MON_NONE = 2'b00,
        MON_LEFT_ADC = 2'b01,
        MON_RIGHT_ADC = 2'b10,
        MON_RESERVED = 2'b11
    } monitor_src_t;
    typedef enum logic [1:0] {
        BOOST_0DB = 2'b00,
        BOOST_6DB = 2'b01,
        BOOST_12DB = 2'b10,
        BOOST_18DB = 2'b11
    } boost_t;
    localparam sample_t SAMPLE_MAX = 24'sh7fffff;
    localparam sample_t SAMPLE_MIN = 24'sh800000;
endpackage

//--- logic/monitor_gain_scaler.sv
// Sidetone gain stage: scales one sample by a 4-bit code, -36 dB to 0 dB.
// Assumes the caller pulses in_valid once per sample; result one cycle later.
`include "mix_router_cfg.svh"

module monitor_gain_scaler import mix_router_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [3:0] gain_code,
    input wire sample_t in_sample,
    output sample_t out_sample
);
    // Unsigned Q1.15 factors; 0 dB is exactly 1.0 so no rounding at unity
    function automatic logic [15:0] gain_coef(input logic [3:0] code);
        case (code)
            4'h0: gain_coef = 16'h0207;
            4'h1: gain_coef = 16'h02de;
            4'h2: gain_coef = 16'h040c;
            4'h3: gain_coef = 16'h05b8;
            4'h4: gain_coef = 16'h0814;
            4'h5: gain_coef = 16'h0b68;
            4'h6: gain_coef = 16'h101d;
            4'h7: gain_coef = 16'h16c3;
            4'h8: gain_coef = 16'h2027;
            4'h9: gain_coef = 16'h2d6b;
            4'ha: gain_coef = 16'h4027;
            4'hb: gain_coef = 16'h5a9e;
            default: gain_coef = 16'h8000;
        endcase
    endfunction

    logic signed [`SAMPLE_W+16:0] product;

    assign product = in_sample * $signed({1'b0, gain_coef(gain_code)});

    always_ff @(posedge clk) begin
        if (rst) begin
            out_sample <= '0;
        end else if (in_valid) begin
            out_sample <= product[`GAIN_FRAC_BITS+`SAMPLE_W-1:`GAIN_FRAC_BITS];
        end
    end
endmodule

//--- logic/audio_digital_mix_router.sv
// Digital mixing and routing core: ADC to interface slots, interface to DACs,
// playback boost and sidetone mix, with a classic Wishbone register slave.
// Assumes ADC, high-pass and interface samples arrive on CLOCK with strobes.
//
// Functional notes
// - Left ADC samples are negated when the left ADC flip bit is set.
// - Right ADC samples are negated when the right ADC flip bit is set.
// - Left transmit slot carries left ADC, or right ADC when bit 7 set.
// - Right transmit slot carries right ADC when bit 6 set, else left ADC.
// - Left playback data is negated when bit 12 is set.
// - Right playback data is negated when bit 11 is set.
// - Left DAC takes left channel, or right channel when bit 5 set.
// - Right DAC takes right channel when bit 4 set, else left channel.
// - Boost field bits 10:9 gives 0, +6, +12 or +18 dB playback gain.
// - Sidetone only mixes when ADC and DAC rates are declared equal.
// - Selected sidetone is added to each DAC channel independently.
// - Sidetone samples come from the ADC high-pass filter output.
// - Left sidetone source bits 3:2: none, left ADC, right ADC, reserved.
// - Right sidetone source bits 1:0 use the same coding.
// - Left sidetone gain is field 11:8, reset to zero.
// - Right sidetone gain is field 7:4, reset to zero.
// - Gain code 0 is -36 dB, 3 dB steps, 0 dB from code 12 up.
`include "mix_router_cfg.svh"

module audio_digital_mix_router import mix_router_pkg::*; (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [`WB_ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic ADC_VALID,
    input wire sample_t ADC_L_RAW,
    input wire sample_t ADC_R_RAW,
    input wire sample_t ADC_L_HPF,
    input wire sample_t ADC_R_HPF,
    output sample_t AIF_TX_L,
    output sample_t AIF_TX_R,
    output logic AIF_TX_VALID,
    input wire logic AIF_RX_VALID,
    input wire sample_t AIF_RX_L,
    input wire sample_t AIF_RX_R,
    output sample_t DAC_L,
    output sample_t DAC_R,
    output logic DAC_VALID
);
    // Negating the most negative code would wrap, so it clips to the top
    function automatic sample_t flip_sample(input sample_t s, input logic en);
        if (!en) begin
            flip_sample = s;
        end else if (s == SAMPLE_MIN) begin
            flip_sample = SAMPLE_MAX;
        end else begin
            flip_sample = -s;
        end
    endfunction

    function automatic logic out_of_range(input logic signed [`SAMPLE_W+2:0] w);
        out_of_range = (w > $signed({{3{1'b0}}, SAMPLE_MAX}))
            || (w < $signed({{3{1'b1}}, SAMPLE_MIN}));
    endfunction

    function automatic sample_t clamp_sample(input logic signed [`SAMPLE_W+2:0] w);
        if (w > $signed({{3{1'b0}}, SAMPLE_MAX})) begin
            clamp_sample = SAMPLE_MAX;
        end else if (w < $signed({{3{1'b1}}, SAMPLE_MIN})) begin
            clamp_sample = SAMPLE_MIN;
        end else begin
            clamp_sample = w[`SAMPLE_W-1:0];
        end
    endfunction

    // Boost by whole-bit shifts: 6.02 dB per step, close to the nominal 6 dB
    function automatic logic signed [`SAMPLE_W+2:0] boost_wide(input sample_t s,
            input boost_t b);
        logic signed [`SAMPLE_W+2:0] w;
        w = {{3{s[`SAMPLE_W-1]}}, s};
        case (b)
            BOOST_6DB: boost_wide = w <<< 1;
            BOOST_12DB: boost_wide = w <<< 2;
            BOOST_18DB: boost_wide = w <<< 3;
            default: boost_wide = w;
        endcase
    endfunction

    function automatic sample_t pick_monitor(input monitor_src_t src,
            input logic rate_ok, input sample_t hl, input sample_t hr);
        if (!rate_ok) begin
            pick_monitor = '0;
        end else begin
            case (src)
                MON_LEFT_ADC: pick_monitor = hl;
                MON_RIGHT_ADC: pick_monitor = hr;
                default: pick_monitor = '0;
            endcase
        end
    endfunction

    function automatic logic [15:0] merge_lanes(input logic [15:0] old,
            input logic [31:0] wd, input logic [3:0] sel, input logic [15:0] mask);
        logic [15:0] m;
        m = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        merge_lanes = (old & ~m) | (wd[15:0] & m);
    endfunction

    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [15:0] routing_reg;
    logic [15:0] sidetone_reg;
    logic [15:0] polarity_reg;
    logic [15:0] mix_ctrl_reg;
    logic [15:0] mix_status_reg;
    logic [15:0] mix_status_next;
    logic [15:0] status_set;
    logic [15:0] status_clr;
    logic access;
    logic wr_access;
    logic [5:0] word_idx;
    logic [15:0] rd_word;

    sample_t adc_l_flipped;
    sample_t adc_r_flipped;
    sample_t tx_l_reg;
    sample_t tx_r_reg;
    logic tx_valid_reg;
    sample_t hpf_l_reg;
    sample_t hpf_r_reg;

    sample_t play_l_pick;
    sample_t play_r_pick;
    logic signed [`SAMPLE_W+2:0] boost_l_wide;
    logic signed [`SAMPLE_W+2:0] boost_r_wide;
    sample_t play_l_reg;
    sample_t play_r_reg;
    logic stage1_valid_reg;
    sample_t mon_l_in;
    sample_t mon_r_in;
    sample_t mon_l_scaled;
    sample_t mon_r_scaled;
    logic signed [`SAMPLE_W+2:0] mix_l_wide;
    logic signed [`SAMPLE_W+2:0] mix_r_wide;
    sample_t dac_l_reg;
    sample_t dac_r_reg;
    logic dac_valid_reg;
    logic rate_ok;
    boost_t boost_sel;

    // Bus slave: one wait state, ack for exactly one cycle per request
    assign access = WB_CYC_I && WB_STB_I && !ack_reg;
    assign wr_access = access && WB_WE_I;
    assign word_idx = WB_ADR_I[`WB_ADR_W-1:2];

    always_comb begin
        case (word_idx)
            `ROUTING_IDX: rd_word = routing_reg;
            `SIDETONE_IDX: rd_word = sidetone_reg;
            `POLARITY_IDX: rd_word = polarity_reg;
            `MIX_CTRL_IDX: rd_word = mix_ctrl_reg;
            `MIX_STATUS_IDX: rd_word = mix_status_reg;
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rdata_reg <= 32'h0000_0000;
        end else if (access) begin
            rdata_reg <= {16'h0000, rd_word};
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdata_reg;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            routing_reg <= `ROUTING_RESET;
        end else if (wr_access && word_idx == `ROUTING_IDX) begin
            routing_reg <= merge_lanes(routing_reg, WB_DAT_I, WB_SEL_I, `ROUTING_WMASK);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            sidetone_reg <= `SIDETONE_RESET;
        end else if (wr_access && word_idx == `SIDETONE_IDX) begin
            sidetone_reg <= merge_lanes(sidetone_reg, WB_DAT_I, WB_SEL_I,
                `SIDETONE_WMASK);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            polarity_reg <= `POLARITY_RESET;
        end else if (wr_access && word_idx == `POLARITY_IDX) begin
            polarity_reg <= merge_lanes(polarity_reg, WB_DAT_I, WB_SEL_I,
                `POLARITY_WMASK);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            mix_ctrl_reg <= `MIX_CTRL_RESET;
        end else if (wr_access && word_idx == `MIX_CTRL_IDX) begin
            mix_ctrl_reg <= merge_lanes(mix_ctrl_reg, WB_DAT_I, WB_SEL_I,
                `MIX_CTRL_WMASK);
        end
    end

    // Sticky clip flags, write one to clear; a new clip in the same cycle wins
    always_comb begin
        status_set = 16'h0000;
        status_set[`ST_BOOST_CLIP_L_BIT] = AIF_RX_VALID && out_of_range(boost_l_wide);
        status_set[`ST_BOOST_CLIP_R_BIT] = AIF_RX_VALID && out_of_range(boost_r_wide);
        status_set[`ST_MIX_CLIP_L_BIT] = stage1_valid_reg && out_of_range(mix_l_wide);
        status_set[`ST_MIX_CLIP_R_BIT] = stage1_valid_reg && out_of_range(mix_r_wide);
        status_clr = 16'h0000;
        if (wr_access && word_idx == `MIX_STATUS_IDX && WB_SEL_I[0]) begin
            status_clr = {8'h00, WB_DAT_I[7:0]};
        end
        mix_status_next = (mix_status_reg & ~status_clr) | status_set;
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            mix_status_reg <= `MIX_STATUS_RESET;
        end else begin
            mix_status_reg <= mix_status_next;
        end
    end

    // Capture path: flip, then route to the transmit slots
    assign adc_l_flipped = flip_sample(ADC_L_RAW, polarity_reg[`ADC_FLIP_L_BIT]);
    assign adc_r_flipped = flip_sample(ADC_R_RAW, polarity_reg[`ADC_FLIP_R_BIT]);

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            tx_l_reg <= '0;
            tx_r_reg <= '0;
        end else if (ADC_VALID) begin
            tx_l_reg <= routing_reg[`TX_SLOT_L_BIT] ? adc_r_flipped : adc_l_flipped;
            tx_r_reg <= routing_reg[`TX_SLOT_R_BIT] ? adc_r_flipped : adc_l_flipped;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            tx_valid_reg <= 1'b0;
        end else begin
            tx_valid_reg <= ADC_VALID;
        end
    end

    assign AIF_TX_L = tx_l_reg;
    assign AIF_TX_R = tx_r_reg;
    assign AIF_TX_VALID = tx_valid_reg;

    // High-pass samples are held so the playback path may run on its own strobe
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            hpf_l_reg <= '0;
            hpf_r_reg <= '0;
        end else if (ADC_VALID) begin
            hpf_l_reg <= ADC_L_HPF;
            hpf_r_reg <= ADC_R_HPF;
        end
    end

    // Playback stage 1: channel select, flip, boost with clamp
    assign boost_sel = boost_t'(routing_reg[`BOOST_HI:`BOOST_LO]);
    assign play_l_pick = routing_reg[`PLAYBACK_SEL_L_BIT] ? AIF_RX_R : AIF_RX_L;
    assign play_r_pick = routing_reg[`PLAYBACK_SEL_R_BIT] ? AIF_RX_R : AIF_RX_L;
    assign boost_l_wide = boost_wide(
        flip_sample(play_l_pick, routing_reg[`PLAYBACK_FLIP_L_BIT]), boost_sel);
    assign boost_r_wide = boost_wide(
        flip_sample(play_r_pick, routing_reg[`PLAYBACK_FLIP_R_BIT]), boost_sel);

    // Host is expected to keep boosted data in range; clamping only limits damage
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            play_l_reg <= '0;
            play_r_reg <= '0;
        end else if (AIF_RX_VALID) begin
            play_l_reg <= clamp_sample(boost_l_wide);
            play_r_reg <= clamp_sample(boost_r_wide);
        end
    end

    // Sidetone source; reserved code and unequal rates both give silence
    assign rate_ok = mix_ctrl_reg[`RATE_MATCH_BIT];
    assign mon_l_in = pick_monitor(monitor_src_t'(sidetone_reg[`MON_SRC_L_HI:`MON_SRC_L_LO]),
        rate_ok, hpf_l_reg, hpf_r_reg);
    assign mon_r_in = pick_monitor(monitor_src_t'(sidetone_reg[`MON_SRC_R_HI:`MON_SRC_R_LO]),
        rate_ok, hpf_l_reg, hpf_r_reg);

    monitor_gain_scaler left_scaler (
        .clk(CLOCK),
        .rst(SYS_RST),
        .in_valid(AIF_RX_VALID),
        .gain_code(sidetone_reg[`MON_GAIN_L_HI:`MON_GAIN_L_LO]),
        .in_sample(mon_l_in),
        .out_sample(mon_l_scaled)
    );

    monitor_gain_scaler right_scaler (
        .clk(CLOCK),
        .rst(SYS_RST),
        .in_valid(AIF_RX_VALID),
        .gain_code(sidetone_reg[`MON_GAIN_R_HI:`MON_GAIN_R_LO]),
        .in_sample(mon_r_in),
        .out_sample(mon_r_scaled)
    );

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            stage1_valid_reg <= 1'b0;
        end else begin
            stage1_valid_reg <= AIF_RX_VALID;
        end
    end

    // Playback stage 2: add sidetone per channel and saturate
    assign mix_l_wide = {{3{play_l_reg[`SAMPLE_W-1]}}, play_l_reg}
        + {{3{mon_l_scaled[`SAMPLE_W-1]}}, mon_l_scaled};
    assign mix_r_wide = {{3{play_r_reg[`SAMPLE_W-1]}}, play_r_reg}
        + {{3{mon_r_scaled[`SAMPLE_W-1]}}, mon_r_scaled};

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            dac_l_reg <= '0;
            dac_r_reg <= '0;
        end else if (stage1_valid_reg) begin
            dac_l_reg <= clamp_sample(mix_l_wide);
            dac_r_reg <= clamp_sample(mix_r_wide);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            dac_valid_reg <= 1'b0;
        end else begin
            dac_valid_reg <= stage1_valid_reg;
        end
    end

    assign DAC_L = dac_l_reg;
    assign DAC_R = dac_r_reg;
    assign DAC_VALID = dac_valid_reg;
endmodule

//--- verification/mix_router_properties.sv
// Port checker for the mix router: bus timing, stream latency, capture routing.
// Assumes it is bound to the top module and sees only its ports.
`include "mix_router_cfg.svh"

module mix_router_properties import mix_router_pkg::*; (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [`WB_ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic ADC_VALID,
    input wire sample_t ADC_L_RAW,
    input wire sample_t ADC_R_RAW,
    input wire sample_t AIF_TX_L,
    input wire sample_t AIF_TX_R,
    input wire logic AIF_TX_VALID,
    input wire logic AIF_RX_VALID,
    input wire sample_t DAC_L,
    input wire logic DAC_VALID
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    logic [1:0] route_reg;
    logic [1:0] flip_reg;
    sample_t exp_l_reg, exp_r_reg, src_l, src_r;
    // Shadow of the routing and ADC flip bits; a write lands at the edge that takes it
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            route_reg <= 2'h1;
            flip_reg <= 2'h0;
        end else if (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0]) begin
            if (WB_ADR_I == 8'h60) route_reg <= WB_DAT_I[7:6];
            if (WB_ADR_I == 8'h98) flip_reg <= WB_DAT_I[1:0];
        end
    end
    assign src_l = flip_reg[1] ? -ADC_L_RAW : ADC_L_RAW;
    assign src_r = flip_reg[0] ? -ADC_R_RAW : ADC_R_RAW;
    always_ff @(posedge CLOCK) begin
        if (ADC_VALID) begin
            exp_l_reg <= route_reg[1] ? src_r : src_l;
            exp_r_reg <= route_reg[0] ? src_r : src_l;
        end
    end
    a_ack_latency: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    a_read_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_tx_latency: assert property (ADC_VALID |=> AIF_TX_VALID)
        else $error("transmit valid late");
    a_tx_left_route: assert property (AIF_TX_VALID |-> AIF_TX_L == exp_l_reg)
        else $error("left transmit slot wrong");
    a_tx_right_route: assert property (AIF_TX_VALID |-> AIF_TX_R == exp_r_reg)
        else $error("right transmit slot wrong");
    a_dac_latency: assert property (AIF_RX_VALID |-> ##2 DAC_VALID)
        else $error("dac valid late");
    a_dac_cause: assert property (DAC_VALID |-> $past(AIF_RX_VALID, 2))
        else $error("dac valid without playback sample");
    a_dac_hold: assert property (!DAC_VALID |-> $stable(DAC_L))
        else $error("dac data moved between samples");
    c_write: cover property (WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O);
    c_flip: cover property (AIF_TX_VALID && flip_reg == 2'h3);
    c_clip: cover property (DAC_VALID && DAC_L == SAMPLE_MAX);
endmodule

bind audio_digital_mix_router mix_router_properties chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .ADC_VALID(ADC_VALID), .ADC_L_RAW(ADC_L_RAW), .ADC_R_RAW(ADC_R_RAW),
    .AIF_TX_L(AIF_TX_L), .AIF_TX_R(AIF_TX_R), .AIF_TX_VALID(AIF_TX_VALID),
    .AIF_RX_VALID(AIF_RX_VALID), .DAC_L(DAC_L), .DAC_VALID(DAC_VALID));

//--- verification/aif_host_model.sv
// Host side of the audio interface: sends playback pairs one at a time.
// Assumes callers enter send just after a rising edge of the clock.
module aif_host_model import mix_router_pkg::*; (
    input wire logic CLOCK,
    output logic AIF_RX_VALID,
    output sample_t AIF_RX_L,
    output sample_t AIF_RX_R
);
    initial begin
        AIF_RX_VALID = 1'b0;
        AIF_RX_L = '0;
        AIF_RX_R = '0;
    end
    // Callers keep boosted levels under full scale, bar the clip
    // Sidetone gains are unity only
    task automatic send(input sample_t l, input sample_t r);
        @(posedge CLOCK);
        AIF_RX_VALID <= 1'b1;
        AIF_RX_L <= l;
        AIF_RX_R <= r;
        @(posedge CLOCK);
        // Idle lines show the inverse so stale data never passes as valid
        AIF_RX_VALID <= 1'b0;
        AIF_RX_L <= ~l;
        AIF_RX_R <= ~r;
    endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench: registers over Wishbone, capture and playback streams.
// Assumes the package, the checker and the host model are compiled first.
module tb_top import mix_router_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, adc_v = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, tx_v, rx_v, dac_v;
    sample_t adc_l = '0, adc_r = '0, hpf_l = '0, hpf_r = '0;
    sample_t tx_l, tx_r, rx_l, rx_r, dac_l, dac_r, hl, hr;
    logic [15:0] rt = 16'h0050, st = 16'h0, pol = 16'h0, ctl = 16'h0;
    logic [7:0] ad [5] = '{8'h60, 8'h80, 8'h98, 8'hc0, 8'h04};
    logic [31:0] rdq [$];
    logic [47:0] txq [$], dacq [$];
    int n_fail = 0, check_count = 0;
    always #4 clock = ~clock;
    audio_digital_mix_router DUT (.CLOCK(clock), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .ADC_VALID(adc_v), .ADC_L_RAW(adc_l), .ADC_R_RAW(adc_r),
        .ADC_L_HPF(hpf_l), .ADC_R_HPF(hpf_r), .AIF_TX_L(tx_l), .AIF_TX_R(tx_r),
        .AIF_TX_VALID(tx_v), .AIF_RX_VALID(rx_v), .AIF_RX_L(rx_l), .AIF_RX_R(rx_r),
        .DAC_L(dac_l), .DAC_R(dac_r), .DAC_VALID(dac_v));
    aif_host_model host (.CLOCK(clock), .AIF_RX_VALID(rx_v), .AIF_RX_L(rx_l), .AIF_RX_R(rx_r));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        if (ack === 1'b1 && we === 1'b0) chk(rdat, rdq.size() ? rdq.pop_front() : 48'hx);
        if (tx_v === 1'b1) chk({tx_l, tx_r}, txq.size() ? txq.pop_front() : 48'hx);
        if (dac_v === 1'b1) begin
            chk({dac_l, dac_r}, dacq.size() ? dacq.pop_front() : 48'hx);
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int i = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= {16'h0, d};
        do begin
            @(posedge clock);
            i++;
        end while (ack !== 1'b1 && i < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        case (a)
            8'h60: rt = d & 16'h1ef0;
            8'h80: st = d & 16'h0fff;
            8'h98: pol = d & 16'h0003;
            8'hc0: ctl = d & 16'h0001;
            default: ;
        endcase
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        rdq.push_back(a == 8'h60 ? rt : a == 8'h80 ? st : a == 8'h98 ? pol : a == 8'hc0 ? ctl : 0);
        wb(1'b0, a, 16'h0);
    endtask
    function automatic sample_t rnd(input int sh);
        return sample_t'($signed($urandom()) >>> sh);
    endfunction
    function automatic sample_t sat(input logic signed [27:0] v);
        return v > SAMPLE_MAX ? SAMPLE_MAX : v < SAMPLE_MIN ? SAMPLE_MIN : v[23:0];
    endfunction
    // Sidetone gain is modelled as unity only, so scenarios use codes 12 to 15
    function automatic sample_t mix(input logic side, input sample_t l, input sample_t r);
        logic signed [27:0] v;
        logic [1:0] src;
        v = (side ? rt[4] : rt[5]) ? r : l;
        if (side ? rt[11] : rt[12]) v = -v;
        v = sat(v <<< rt[10:9]);
        src = side ? st[1:0] : st[3:2];
        if (ctl[0] && src == 2'b01) v = v + hl;
        if (ctl[0] && src == 2'b10) v = v + hr;
        return sat(v);
    endfunction
    task automatic adc(input sample_t l, input sample_t r, input sample_t a, input sample_t b);
        sample_t xl, xr;
        xl = pol[1] ? -l : l;
        xr = pol[0] ? -r : r;
        txq.push_back({rt[7] ? xr : xl, rt[6] ? xr : xl});
        hl = a;
        hr = b;
        @(posedge clock);
        adc_v <= 1'b1;
        {adc_l, adc_r, hpf_l, hpf_r} <= {l, r, a, b};
        @(posedge clock);
        adc_v <= 1'b0;
        {adc_l, adc_r, hpf_l, hpf_r} <= ~{l, r, a, b};
    endtask
    task automatic play(input sample_t l, input sample_t r);
        dacq.push_back({mix(1'b0, l, r), mix(1'b1, l, r)});
        host.send(l, r);
    endtask
    initial begin
        void'($urandom(32'h1171));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        foreach (ad[i]) rd(ad[i]);
        foreach (ad[i]) begin
            wr(ad[i], 16'hffff);
            rd(ad[i]);
        end
        wr(8'h60, 16'h0050);
        wr(8'h80, 16'h0000);
        wr(8'hc0, 16'h0000);
        $display("registers done");
        for (int k = 0; k < 16; k++) begin
            wr(8'h60, {8'h00, k[3:2], 6'h10});
            wr(8'h98, {14'h0, k[1:0]});
            adc(rnd(9), rnd(9), rnd(9), rnd(9));
        end
        wr(8'h98, 16'h0000);
        $display("capture done");
        for (int k = 0; k < 64; k++) begin
            wr(8'h60, {3'h0, k[5:2], 3'h1, k[1:0], 4'h0});
            play(rnd(12), rnd(12));
        end
        wr(8'h60, 16'h0050);
        $display("playback done");
        adc(rnd(9), rnd(9), rnd(9), rnd(9));
        wr(8'h80, 16'h0cc5);
        play(rnd(10), rnd(10));
        wr(8'hc0, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            wr(8'h80, {4'h0, 4'hc, 4'hf, k[1:0], ~k[1:0]});
            play(rnd(10), rnd(10));
        end
        wr(8'h80, 16'h0cc6);
        wr(8'h60, 16'h0250);
        adc(24'sh000000, 24'sh000000, 24'sh400000, -24'sh400000);
        play(24'sh500000, -24'sh500000);
        // Boost and mix both clip on each side, so all four sticky flags are up
        rdq.push_back(32'h0000_000f);
        wb(1'b0, 8'hc4, 16'h0000);
        wb(1'b1, 8'hc4, 16'h000f);
        rd(8'hc4);
        $display("sidetone done");
        repeat (4) @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        chk({dac_l, dac_r}, 48'h0);
        {rt, st, pol, ctl} = {16'h0050, 16'h0, 16'h0, 16'h0};
        foreach (ad[i]) rd(ad[i]);
        repeat (4) @(posedge clock);
        chk(rdq.size() + txq.size() + dacq.size(), 48'h0);
        $display("reset done");
        end_of_test();
    end
endmodule
